// *** design/dao_fifo.sv ***
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "dao_params.svh"

module dao_fifo #(
   parameter int WIDTH = `DAO_CODE_W,
   parameter int DEPTH = `DAO_FIFO_DEPTH
) (
   input wire logic core_clk, // Core clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic [WIDTH-1:0] in_data, // Word to store
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room for a word
   output logic [WIDTH-1:0] out_data, // Oldest word
   output logic out_valid, // Oldest word present
   input wire logic out_ready // Oldest word taken
);

   localparam int AW = $clog2(DEPTH);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("dao_fifo: DEPTH must be a power of two of at least 2");
   end

   // ---------------------------------------------------------------
   // Storage and pointers
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] count_q;
   logic [AW:0] count_d;
   logic ready_q;
   logic push;
   logic pop;

   assign push = in_valid & ready_q;
   assign pop = out_valid & out_ready;
   assign in_ready = ready_q;
   assign out_valid = (count_q != '0);
   assign out_data = mem_q[rd_q];

   always_comb
   begin
      count_d = count_q;
      if (push && !pop)
      begin
         count_d = count_q + (AW + 1)'(1);
      end
      else if (pop && !push)
      begin
         count_d = count_q - (AW + 1)'(1);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
         ready_q <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + AW'(1);
         end
         if (pop)
         begin
            rd_q <= rd_q + AW'(1);
         end
         count_q <= count_d;
         ready_q <= (count_d != (AW + 1)'(DEPTH));
      end
   end

endmodule : dao_fifo

// *** design/dao_params.svh ***
// Constants of the dual converter output interface.
// Assumes inclusion by bare name from design files under design/.
`ifndef DAO_PARAMS_SVH
`define DAO_PARAMS_SVH

// ---------------------------------------------------------------
// Result word layout
// ---------------------------------------------------------------
`define DAO_CODE_W 8
`define DAO_MSB_POS 7
`define DAO_LSB_POS 0

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define DAO_RESET_CODE 8'h00
`define DAO_LATENCY 5
`define DAO_FIFO_DEPTH 4

`endif

// *** design/dao_pkg.sv ***
// Types shared by the dual converter output interface.
// Assumes dao_params.svh for the word layout.
`include "dao_params.svh"

package dao_pkg;

   // ---------------------------------------------------------------
   // One channel result: sign-bearing msb and the remaining bits
   // ---------------------------------------------------------------
   typedef struct packed {
      logic msb;
      logic [`DAO_MSB_POS-1:`DAO_LSB_POS] body;
   } dao_code_t;

endpackage : dao_pkg

// *** design/dao_top.sv ***
// Digital output side of a dual-channel 8-bit pipelined converter.
// Assumes raw codes arrive from core logic on core_clk; the sample
// clocks and the static straps arrive as pins and are synchronised.
//
// Functional notes
// - Each result reaches its output latch 5 sample clocks after sampling.
// - Format select low gives offset binary; high inverts the msb.
// - I result is 8 bits, bit 7 msb, bit 0 lsb.
// - Q result is 8 bits, bit 0 lsb, bit 7 msb.
// - Each channel is fully pipelined, taking a sample every clock.
`timescale 1ns/1ps
`include "dao_params.svh"

module dao_top #(
   parameter int LATENCY = `DAO_LATENCY,
   parameter int FIFO_DEPTH = `DAO_FIFO_DEPTH
) (
   input wire logic core_clk, // Core clock, 200 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic i_channel_sample_clock, // I sample clock pin
   input wire logic q_channel_sample_clock, // Q sample clock pin
   input wire logic output_format_select, // 0 offset binary, 1 twos
   input wire logic mode_select_first, // Mode strap 1
   input wire logic mode_select_second, // Mode strap 2
   input wire logic [`DAO_MSB_POS:`DAO_LSB_POS] i_code_in, // I raw code
   input wire logic i_code_valid, // I raw code offered
   output logic i_code_ready, // I buffer has room
   input wire logic [`DAO_MSB_POS:`DAO_LSB_POS] q_code_in, // Q raw code
   input wire logic q_code_valid, // Q raw code offered
   output logic q_code_ready, // Q buffer has room
   output logic [`DAO_MSB_POS:`DAO_LSB_POS] i_result, // I output latch
   output logic [`DAO_MSB_POS:`DAO_LSB_POS] q_result, // Q output latch
   output logic i_result_update, // I latch reloaded
   output logic q_result_update, // Q latch reloaded
   output logic [1:0] mode_select_q // Synchronised mode straps
);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (LATENCY < 1)
   begin : g_bad_latency
      $error("dao_top: LATENCY must be at least 1");
   end

   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("dao_top: FIFO_DEPTH must be a power of two of at least 2");
   end

   // ---------------------------------------------------------------
   // Pin synchronisers for straps
   // ---------------------------------------------------------------
   logic fmt_meta_q;
   logic fmt_q;
   logic [1:0] mode_meta_q;
   logic [1:0] mode_q;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         fmt_meta_q <= 1'b0;
         fmt_q <= 1'b0;
      end
      else
      begin
         fmt_meta_q <= output_format_select;
         fmt_q <= fmt_meta_q;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         mode_meta_q <= 2'h0;
         mode_q <= 2'h0;
      end
      else
      begin
         mode_meta_q <= {mode_select_second, mode_select_first};
         mode_q <= mode_meta_q;
      end
   end

   assign mode_select_q = mode_q;

   // ---------------------------------------------------------------
   // Per-channel wiring: index 0 is I, index 1 is Q
   // ---------------------------------------------------------------
   logic [1:0] sclk_pin;
   logic [1:0] code_valid;
   logic [1:0] code_ready;
   logic [1:0] update_q;
   dao_pkg::dao_code_t code_in [2];
   dao_pkg::dao_code_t result_q [2];

   assign sclk_pin = {q_channel_sample_clock, i_channel_sample_clock};
   assign code_valid = {q_code_valid, i_code_valid};
   assign code_in[0] = i_code_in;
   assign code_in[1] = q_code_in;
   assign i_code_ready = code_ready[0];
   assign q_code_ready = code_ready[1];
   assign i_result = result_q[0];
   assign q_result = result_q[1];
   assign i_result_update = update_q[0];
   assign q_result_update = update_q[1];

   // ---------------------------------------------------------------
   // Channel pipelines
   // ---------------------------------------------------------------
   for (genvar ch = 0; ch < 2; ch++)
   begin : g_chan
      logic sclk_meta_q;
      logic sclk_sync_q;
      logic sclk_prev_q;
      logic sample_edge;
      logic head_valid;
      logic [`DAO_CODE_W-1:0] head_data;
      dao_pkg::dao_code_t last_q;
      dao_pkg::dao_code_t taken;
      dao_pkg::dao_code_t pipe_q [LATENCY];
      dao_pkg::dao_code_t result_d;

      // Rising edge of this channel's sample clock; a shared clock
      // on both pins simply makes both channels step together.
      always_ff @(posedge core_clk)
      begin
         if (!rst_n)
         begin
            sclk_meta_q <= 1'b0;
            sclk_sync_q <= 1'b0;
            sclk_prev_q <= 1'b0;
         end
         else
         begin
            sclk_meta_q <= sclk_pin[ch];
            sclk_sync_q <= sclk_meta_q;
            sclk_prev_q <= sclk_sync_q;
         end
      end

      assign sample_edge = sclk_sync_q & ~sclk_prev_q;

      // Raw codes wait here until their sample clock edge
      dao_fifo #(
         .WIDTH(`DAO_CODE_W),
         .DEPTH(FIFO_DEPTH)
      ) u_fifo (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .in_data(code_in[ch]),
         .in_valid(code_valid[ch]),
         .in_ready(code_ready[ch]),
         .out_data(head_data),
         .out_valid(head_valid),
         .out_ready(sample_edge)
      );

      // An empty buffer at an edge repeats the previous sample
      assign taken = head_valid ? dao_pkg::dao_code_t'(head_data) : last_q;

      always_ff @(posedge core_clk)
      begin
         if (!rst_n)
         begin
            last_q <= `DAO_RESET_CODE;
         end
         else if (sample_edge)
         begin
            last_q <= taken;
         end
      end

      always_ff @(posedge core_clk)
      begin
         if (!rst_n)
         begin
            for (int s = 0; s < LATENCY; s++)
            begin
               pipe_q[s] <= `DAO_RESET_CODE;
            end
         end
         else if (sample_edge)
         begin
            pipe_q[0] <= taken;
            for (int s = 1; s < LATENCY; s++)
            begin
               pipe_q[s] <= pipe_q[s-1];
            end
         end
      end

      // Two's complement differs from offset binary only in the msb
      always_comb
      begin
         result_d = pipe_q[LATENCY-1];
         result_d.msb = pipe_q[LATENCY-1].msb ^ fmt_q;
      end

      // Output latch: loaded from the last stage on the fifth edge
      always_ff @(posedge core_clk)
      begin
         if (!rst_n)
         begin
            result_q[ch] <= `DAO_RESET_CODE;
         end
         else if (sample_edge)
         begin
            result_q[ch] <= result_d;
         end
      end

      // Reload strobe, high in the cycle the new result appears
      always_ff @(posedge core_clk)
      begin
         if (!rst_n)
         begin
            update_q[ch] <= 1'b0;
         end
         else
         begin
            update_q[ch] <= sample_edge;
         end
      end
   end

endmodule : dao_top

// *** testbench/dao_capture.sv ***
// Capture logic model: makes the shared sample clock, logs results.
// Assumes core_clk and results from dao_top.
`timescale 1ns/1ps
module dao_capture (
   input wire logic core_clk, // Core clock
   input wire logic [7:0] i_result, // I latch
   input wire logic [7:0] q_result, // Q latch
   input wire logic i_result_update, // I reload
   input wire logic q_result_update, // Q reload
   output logic sample_clk // One clock for both channels
);
   logic [7:0] iq [$];
   logic [7:0] qq [$];
   initial sample_clk = 1'b0;
   // Results are logged mid-cycle, where they have settled
   always @(negedge core_clk)
   begin
      if (i_result_update === 1'b1)
         iq.push_back(i_result);
      if (q_result_update === 1'b1)
         qq.push_back(q_result);
   end
   // Four core cycles high, four low; idle low between frames
   task pulse(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         #1 sample_clk = 1'b1;
         repeat (4) @(posedge core_clk);
         #1 sample_clk = 1'b0;
         repeat (3) @(posedge core_clk);
      end
   endtask : pulse
endmodule : dao_capture

// *** testbench/dao_top_sva.sv ***
// Checker of the dual converter output interface.
// Assumes binding to dao_top; sees its ports only.
`timescale 1ns/1ps
module dao_top_chk (
   input wire logic core_clk, // Core clock
   input wire logic rst_n, // Reset, active low
   input wire logic i_channel_sample_clock, // I sample pin
   input wire logic q_channel_sample_clock, // Q sample pin
   input wire logic mode_select_first, // Strap 1
   input wire logic mode_select_second, // Strap 2
   input wire logic i_code_ready, // I room
   input wire logic q_code_ready, // Q room
   input wire logic [7:0] i_result, // I latch
   input wire logic [7:0] q_result, // Q latch
   input wire logic i_result_update, // I reload
   input wire logic q_result_update, // Q reload
   input wire logic [1:0] mode_select_q // Echoed straps
);
   // ---------------------------------------------------------------
   // Strap stability count
   // ---------------------------------------------------------------
   logic [1:0] m_q;
   logic [1:0] cnt_q;
   always_ff @(posedge core_clk)
   begin
      m_q <= {mode_select_second, mode_select_first};
      if (!rst_n || m_q != {mode_select_second, mode_select_first})
         cnt_q <= 2'h0;
      else if (cnt_q != 2'h3)
         cnt_q <= cnt_q + 2'h1;
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_quiet(u); !u [*3]; endsequence
   sequence s_ready_up(r); !r ##1 r; endsequence
   a_i_upd_edge: assert property (i_result_update |->
      $past(i_channel_sample_clock, 2) || $past(i_channel_sample_clock, 3))
      else $error("I update without a sample edge");
   a_q_upd_edge: assert property (q_result_update |->
      $past(q_channel_sample_clock, 2) || $past(q_channel_sample_clock, 3))
      else $error("Q update without a sample edge");
   a_i_upd_single: assert property (i_result_update |=>
      s_quiet(i_result_update)) else $error("I update too long");
   a_q_upd_single: assert property (q_result_update |=>
      s_quiet(q_result_update)) else $error("Q update too long");
   a_i_res_hold: assert property (!$stable(i_result) |->
      i_result_update) else $error("I result moved alone");
   a_q_res_hold: assert property (!$stable(q_result) |->
      q_result_update) else $error("Q result moved alone");
   a_i_ready_rst: assert property ($rose(rst_n) |->
      s_ready_up(i_code_ready)) else $error("I ready wrong after reset");
   a_q_ready_rst: assert property ($rose(rst_n) |->
      s_ready_up(q_code_ready)) else $error("Q ready wrong after reset");
   a_mode_echo: assert property (cnt_q == 2'h3 |-> mode_select_q ==
      {mode_select_second, mode_select_first}) else $error("Strap echo");
endmodule : dao_top_chk
bind dao_top dao_top_chk chk (.core_clk(core_clk), .rst_n(rst_n),
   .i_channel_sample_clock(i_channel_sample_clock),
   .q_channel_sample_clock(q_channel_sample_clock),
   .mode_select_first(mode_select_first),
   .mode_select_second(mode_select_second),
   .i_code_ready(i_code_ready), .q_code_ready(q_code_ready),
   .i_result(i_result), .q_result(q_result),
   .i_result_update(i_result_update), .q_result_update(q_result_update),
   .mode_select_q(mode_select_q));

// *** testbench/test_dual_adc_output_interface.sv ***
// Bench of the dual converter output interface.
// Assumes dao_top, dao_capture and the checker bind.
`timescale 1ns/1ps
module test_dual_adc_output_interface;
   logic core_clk = 1'b0, rst_n = 1'b0, fmt = 1'b0, sclk;
   logic ms1 = 1'b0, ms2 = 1'b1, iv = 1'b0, qv = 1'b0;
   logic [7:0] id = 8'h00, qd = 8'h00, ir, qr;
   logic irdy, qrdy, iu, qu;
   logic [1:0] msq;
   int err_total = 0, num_checks = 0;
   always #2.5 core_clk = ~core_clk;
   dao_top dut (.core_clk(core_clk), .rst_n(rst_n),
      .i_channel_sample_clock(sclk), .q_channel_sample_clock(sclk),
      .output_format_select(fmt), .mode_select_first(ms1),
      .mode_select_second(ms2), .i_code_in(id), .i_code_valid(iv),
      .i_code_ready(irdy), .q_code_in(qd), .q_code_valid(qv),
      .q_code_ready(qrdy), .i_result(ir), .q_result(qr),
      .i_result_update(iu), .q_result_update(qu), .mode_select_q(msq));
   dao_capture cap (.core_clk(core_clk), .i_result(ir), .q_result(qr),
      .i_result_update(iu), .q_result_update(qu), .sample_clk(sclk));
   task end_of_test;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task push(input logic [7:0] w);
      int n;
      n = 0;
      id = w;
      qd = ~w;
      iv = 1'b1;
      qv = 1'b1;
      while (!(irdy === 1'b1 && qrdy === 1'b1) && n < 20)
      begin
         @(posedge core_clk);
         #1 n++;
      end
      if (n >= 20)
      begin
         chk(1, 0);
         end_of_test();
      end
      @(posedge core_clk);
      #1;
   endtask : push
   task settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : settle
   task t_mode;
      chk(msq, 2'h2);
   endtask : t_mode
   task t_fill_latency;
      logic [7:0] e;
      for (int k = 0; k < 4; k++) push(8'h1e + 8'h40 * k);
      iv = 1'b0;
      qv = 1'b0;
      settle(1);
      chk({irdy, qrdy}, 2'h0);
      // A word offered into a full buffer must be refused
      id = 8'h3c;
      qd = 8'hc3;
      iv = 1'b1;
      qv = 1'b1;
      settle(3);
      chk({irdy, qrdy}, 2'h0);
      iv = 1'b0;
      qv = 1'b0;
      cap.pulse(10);
      settle(12);
      chk(cap.iq.size() + cap.qq.size(), 20);
      for (int j = 5; j < 10 && cap.iq.size() == 10; j++)
      begin
         e = 8'h1e + 8'h40 * ((j < 8) ? j - 5 : 3);
         chk(cap.iq[j], e);
         chk(cap.qq[j], 8'(~e));
      end
   endtask : t_fill_latency
   task t_format;
      logic [7:0] e;
      fmt = 1'b1;
      settle(4);
      push(8'h2a);
      push(8'h91);
      iv = 1'b0;
      qv = 1'b0;
      cap.pulse(7);
      settle(12);
      chk(cap.iq.size(), 17);
      for (int j = 0; j < 7 && cap.qq.size() == 17; j++)
      begin
         e = (j < 5) ? 8'hde : ((j == 5) ? 8'h2a : 8'h91);
         chk(cap.iq[10 + j], e ^ 8'h80);
         chk(cap.qq[10 + j], 8'(~e ^ 8'h80));
      end
   endtask : t_format
   initial
   begin
      settle(6);
      rst_n = 1'b1;
      settle(4);
      t_mode();
      t_fill_latency();
      t_format();
      end_of_test();
   end
endmodule : test_dual_adc_output_interface
